// File: rtl/lcd_panel_controller.sv
/*
 * Panel controller: frame fetch as a bus master, two display buffers,
 * palette lookup, cursor overlay in single-panel mode, panel timing and pixel output.
 * Assumes configuration ports are held steady while enable is high and
 * that the attached bus follows single-beat AHB-Lite read signalling.
 */
`timescale 1ns/1ps
module lcd_panel_controller
   import lcd_pkg::*;
(
   input  wire logic                         mclk,
   input  wire logic                         rst,
   input  wire logic                         enable,
   input  wire logic [1:0]                   panelType,
   input  wire logic                         dualPanel,
   input  wire logic                         mono8Bit,
   input  wire logic [2:0]                   bppSel,
   input  wire logic [1:0]                   pixOrder,
   input  wire logic                         useExtClk,
   input  wire logic                         pixClkIn,
   input  wire logic [lcd_pkg::DIV_W-1:0]    pixDiv,
   input  wire logic [lcd_pkg::POS_W-1:0]    hActive,
   input  wire logic [lcd_pkg::PORCH_W-1:0]  hFront,
   input  wire logic [lcd_pkg::PORCH_W-1:0]  hSyncW,
   input  wire logic [lcd_pkg::PORCH_W-1:0]  hBack,
   input  wire logic [lcd_pkg::POS_W-1:0]    vActive,
   input  wire logic [lcd_pkg::PORCH_W-1:0]  vFront,
   input  wire logic [lcd_pkg::PORCH_W-1:0]  vSyncW,
   input  wire logic [lcd_pkg::PORCH_W-1:0]  vBack,
   input  wire logic [31:0]                  upperBase,
   input  wire logic [31:0]                  lowerBase,
   input  wire logic [lcd_pkg::WORDS_W-1:0]  panelWords,
   input  wire logic                         palWrEn,
   input  wire logic [6:0]                   palWrAddr,
   input  wire logic [31:0]                  palWrData,
   input  wire logic                         cursorEn,
   input  wire logic [lcd_pkg::POS_W-1:0]    cursorX,
   input  wire logic [lcd_pkg::POS_W-1:0]    cursorY,
   input  wire logic [lcd_pkg::DATA_W-1:0]   cursorColor,
   input  wire logic                         underflowIrqEn,
   input  wire logic                         underflowClr,
   output logic      [31:0]                  hAddr,
   output logic      [1:0]                   hTrans,
   output logic      [2:0]                   hSize,
   output logic                              hWrite,
   input  wire logic                         hReady,
   input  wire logic [31:0]                  hRData,
   output logic                              lcdPixClk,
   output logic                              lcdLineSync,
   output logic                              lcdFrameSync,
   output logic                              lcdAcBias,
   output logic      [lcd_pkg::DATA_W-1:0]   lcdData,
   output logic                              lcdUnderflow,
   output logic                              lcdIrq
);
   typedef enum logic [1:0] {D_IDLE, D_ADDR, D_DATA, D_PUSH} dma_t;

   logic [DIV_W-1:0]   divCnt;
   logic               extS1, extS2, extS3, extLevel;
   logic               divTick, extRise, pixEn;
   logic [POS_W-1:0]   hCnt, vCnt, hTotal, vTotal, hSyncAt, vSyncAt;
   logic               hAct, vAct, hSyncA, vSyncA, activeArea, fetchHold;
   logic               acToggle;
   logic [2:0]         code;
   logic [5:0]         lastIdx;
   logic [63:0]        ent [2];
   logic [5:0]         idx [2];
   logic [1:0]         have, need, fifoValid, fifoReady, fifoRoom;
   logic [63:0]        fifoData [2];
   logic [23:0]        raw [2];
   logic [15:0]        palOut [2];
   logic [11:0]        half12 [2];
   logic [23:0]        pixOut;
   logic               ufEvent, next_underflow, curHit;
   dma_t               dState;
   logic               tgt, wordHalf;
   logic [31:0]        word0, fAddr [2];
   logic [WORDS_W-1:0] wordsLeft [2];
   logic [63:0]        pair;

   // Pixel clock source: divider of mclk or a synchronised pin
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         divCnt    <= '0;
         lcdPixClk <= 1'b0;
         extS1     <= 1'b0;
         extS2     <= 1'b0;
         extS3     <= 1'b0;
         extLevel  <= 1'b0;
      end
      else
      begin
         extS1 <= pixClkIn;
         extS2 <= extS1;
         extS3 <= extS2;
         if (extS2 == extS3)
            extLevel <= extS3;
         divCnt <= divTick ? '0 : divCnt + 1'b1;
         if (useExtClk)
            lcdPixClk <= extLevel;
         else if (divTick)
            lcdPixClk <= ~lcdPixClk;
      end
   end

   assign divTick = divCnt == pixDiv;
   assign extRise = (extS2 == extS3) && extS3 && !extLevel;
   // From the divider, data moves on the falling panel edge; from the pin, one mclk before the rising edge
   assign pixEn = enable && (useExtClk ? extRise : (divTick && lcdPixClk));

   // Raster counters
   assign hTotal  = hActive + POS_W'(hFront) + POS_W'(hSyncW) + POS_W'(hBack);
   assign vTotal  = vActive + POS_W'(vFront) + POS_W'(vSyncW) + POS_W'(vBack);
   assign hSyncAt = hActive + POS_W'(hFront);
   assign vSyncAt = vActive + POS_W'(vFront);
   assign hAct    = hCnt < hActive;
   assign vAct    = vCnt < vActive;
   assign hSyncA  = (hCnt >= hSyncAt) && (hCnt < hSyncAt + POS_W'(hSyncW));
   assign vSyncA  = (vCnt >= vSyncAt) && (vCnt < vSyncAt + POS_W'(vSyncW));
   assign activeArea = hAct && vAct;
   // Fetch restarts every vertical sync so a lost word never skews later frames
   assign fetchHold  = !enable || vSyncA;

   always_ff @(posedge mclk)
   begin
      if (rst || !enable)
      begin
         hCnt <= '0;
         vCnt <= '0;
      end
      else if (pixEn)
      begin
         if (hCnt >= hTotal - 1'b1)
         begin
            hCnt <= '0;
            vCnt <= (vCnt >= vTotal - 1'b1) ? '0 : vCnt + 1'b1;
         end
         else
            hCnt <= hCnt + 1'b1;
      end
   end

   // Effective depth: 24 bpp falls back on STN, mono stops at 4 bpp
   always_comb
   begin
      code = bppSel;
      if (bppSel == BPP_24 && panelType != PANEL_TFT)
         code = BPP_16;
      if (panelType == PANEL_MONO_STN && bppSel > BPP_4)
         code = BPP_4;
   end
   assign lastIdx = 6'h3F >> code;

   function automatic logic [23:0] pick(input logic [63:0] w, input logic [5:0] i,
                                        input logic [2:0] c, input logic [1:0] ord);
      logic [6:0]  off;
      logic [6:0]  wid;
      logic [63:0] sh;
      wid = 7'h01 << c;
      off = 7'(i) << c;
      if (ord == ORDER_BE)
         off = 7'h40 - off - wid;
      else if (ord == ORDER_PACKED && c < BPP_8)
         off = (off & 7'h78) + 7'h08 - wid - (off & 7'h07);
      sh = w >> off;
      unique case (c)
         BPP_1:   pick = {23'h00_0000, sh[0]};
         BPP_2:   pick = {22'h00_0000, sh[1:0]};
         BPP_4:   pick = {20'h0_0000, sh[3:0]};
         BPP_8:   pick = {16'h0000, sh[7:0]};
         BPP_16:  pick = {8'h00, sh[15:0]};
         default: pick = sh[23:0];
      endcase
   endfunction

   // Per-panel pixel take-out; the lower panel runs only in dual mode
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         need[p]      = pixEn && activeArea && (p == 0 || dualPanel);
         fifoReady[p] = need[p] && !have[p];
         raw[p]       = have[p] ? pick(ent[p], idx[p], code, pixOrder)
                                : pick(fifoData[p], 6'h00, code, pixOrder);
      end
   end
   assign ufEvent = |(need & ~have & ~fifoValid);

   always_ff @(posedge mclk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (rst || fetchHold)
         begin
            have[p] <= 1'b0;
            idx[p]  <= '0;
            ent[p]  <= '0;
         end
         else if (need[p])
         begin
            if (have[p])
            begin
               idx[p] <= idx[p] + 1'b1;
               if (idx[p] == lastIdx)
                  have[p] <= 1'b0;
            end
            else if (fifoValid[p])
            begin
               ent[p]  <= fifoData[p];
               idx[p]  <= 6'h01;
               have[p] <= 1'b1;
            end
         end
      end
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_buf
      lcd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
         .mclk     (mclk),
         .rst      (rst),
         .flush    (fetchHold),
         .inValid  (dState == D_PUSH && tgt == 1'(g)),
         .inReady  (fifoRoom[g]),
         .inData   (pair),
         .outValid (fifoValid[g]),
         .outReady (fifoReady[g]),
         .outData  (fifoData[g])
      );
   end

   lcd_palette u_palette (
      .mclk      (mclk),
      .palWrEn   (palWrEn),
      .palWrAddr (palWrAddr),
      .palWrData (palWrData),
      .rdIdxA    (raw[0][7:0]),
      .rdIdxB    (raw[1][7:0]),
      .rdEntryA  (palOut[0]),
      .rdEntryB  (palOut[1])
   );

   // Colour forming: palette entries are 5:5:5, direct 16 bpp is 5:6:5
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (panelType == PANEL_MONO_STN)
            half12[p] = mono8Bit ? {4'h0, palOut[p][3:0], palOut[p][3:0]}
                                 : {8'h00, palOut[p][3:0]};
         else if (code == BPP_16)
            half12[p] = {raw[p][15:12], raw[p][10:7], raw[p][4:1]};
         else
            half12[p] = {palOut[p][14:11], palOut[p][9:6], palOut[p][4:1]};
      end
      if (panelType == PANEL_TFT)
      begin
         if (code == BPP_24)
            pixOut = raw[0];
         else if (code == BPP_16)
            pixOut = {raw[0][15:11], raw[0][15:13], raw[0][10:5], raw[0][10:9],
                      raw[0][4:0], raw[0][4:2]};
         else
            pixOut = {palOut[0][14:10], palOut[0][14:12], palOut[0][9:5],
                      palOut[0][9:7], palOut[0][4:0], palOut[0][4:2]};
      end
      else
         pixOut = {dualPanel ? half12[1] : 12'h000, half12[0]};
   end

   assign curHit = cursorEn && !dualPanel && hCnt >= cursorX
                && hCnt < cursorX + POS_W'(CURSOR_SIZE) && vCnt >= cursorY
                && vCnt < cursorY + POS_W'(CURSOR_SIZE);

   // Panel outputs, all updated on the pixel enable
   always_ff @(posedge mclk)
   begin
      if (rst || !enable)
      begin
         lcdLineSync  <= 1'b0;
         lcdFrameSync <= 1'b0;
         lcdAcBias    <= 1'b0;
         lcdData      <= '0;
         acToggle     <= 1'b0;
      end
      else if (pixEn)
      begin
         lcdLineSync  <= hSyncA;
         lcdFrameSync <= vSyncA;
         if (hCnt == '0 && vCnt == '0)
            acToggle <= ~acToggle;
         lcdAcBias <= (panelType == PANEL_TFT) ? activeArea : acToggle;
         if (!activeArea)
            lcdData <= '0;
         else if (curHit)
            lcdData <= cursorColor;
         else
            lcdData <= pixOut;
      end
   end

   // Underflow: a new event wins over a clear in the same cycle
   assign next_underflow = ufEvent || (lcdUnderflow && !underflowClr);
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lcdUnderflow <= 1'b0;
         lcdIrq       <= 1'b0;
      end
      else
      begin
         lcdUnderflow <= next_underflow;
         lcdIrq       <= next_underflow && underflowIrqEn;
      end
   end

   // Frame fetch master: single word reads, two words make a buffer entry
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dState   <= D_IDLE;
         hTrans   <= HTRANS_IDLE;
         hAddr    <= '0;
         hSize    <= HSIZE_WORD;
         hWrite   <= 1'b0;
         tgt      <= 1'b0;
         wordHalf <= 1'b0;
         word0    <= '0;
         pair     <= '0;
         fAddr[0] <= '0;
         fAddr[1] <= '0;
         wordsLeft[0] <= '0;
         wordsLeft[1] <= '0;
      end
      else
      begin
         unique case (dState)
            D_IDLE:
            begin
               wordHalf <= 1'b0;
               if (fetchHold)
               begin
                  fAddr[0]     <= upperBase;
                  fAddr[1]     <= lowerBase;
                  wordsLeft[0] <= panelWords;
                  wordsLeft[1] <= dualPanel ? panelWords : '0;
                  tgt          <= 1'b0;
               end
               else if (wordsLeft[tgt] != '0)
               begin
                  hAddr  <= fAddr[tgt];
                  hTrans <= HTRANS_NONSEQ;
                  dState <= D_ADDR;
               end
               else if (dualPanel)
                  tgt <= ~tgt;
            end
            D_ADDR:
               if (hReady)
               begin
                  hTrans         <= HTRANS_IDLE;
                  fAddr[tgt]     <= fAddr[tgt] + WORD_BYTES;
                  wordsLeft[tgt] <= wordsLeft[tgt] - 1'b1;
                  dState         <= D_DATA;
               end
            D_DATA:
               if (hReady)
               begin
                  if (fetchHold)
                     dState <= D_IDLE;
                  else if (wordHalf)
                  begin
                     pair   <= {hRData, word0};
                     dState <= D_PUSH;
                  end
                  else if (wordsLeft[tgt] != '0)
                  begin
                     word0    <= hRData;
                     wordHalf <= 1'b1;
                     hAddr    <= fAddr[tgt];
                     hTrans   <= HTRANS_NONSEQ;
                     dState   <= D_ADDR;
                  end
                  else
                  begin
                     pair   <= {32'h0000_0000, hRData};
                     dState <= D_PUSH;
                  end
               end
            D_PUSH:
               // Waits here while the buffer is full, which stalls fetching
               if (fetchHold || fifoRoom[tgt])
               begin
                  dState <= D_IDLE;
                  if (dualPanel)
                     tgt <= ~tgt;
               end
         endcase
      end
   end
endmodule

// File: rtl/lcd_pkg.sv
/*
 * Shared constants of the panel controller: counter widths, buffer shape,
 * palette shape, pixel-depth, panel-type and ordering codes, bus codes.
 * Assumes all users import the package whole.
 */
package lcd_pkg;
   localparam int POS_W      = 12;
   localparam int H_MAX      = 1024;
   localparam int V_MAX      = 768;
   localparam int PORCH_W    = 8;
   localparam int DIV_W      = 8;
   localparam int WORDS_W    = 20;
   localparam int FIFO_W     = 64;
   localparam int FIFO_DEPTH = 16;
   localparam int PAL_WORDS  = 128;
   localparam int PAL_IDX_W  = 8;
   localparam int CURSOR_SIZE = 32;
   localparam int DATA_W     = 24;
   // Pixel depth codes; the code is also log2 of the stored bits per pixel
   localparam logic [2:0] BPP_1  = 3'h0;
   localparam logic [2:0] BPP_2  = 3'h1;
   localparam logic [2:0] BPP_4  = 3'h2;
   localparam logic [2:0] BPP_8  = 3'h3;
   localparam logic [2:0] BPP_16 = 3'h4;
   localparam logic [2:0] BPP_24 = 3'h5;
   localparam logic [1:0] PANEL_MONO_STN  = 2'h0;
   localparam logic [1:0] PANEL_COLOR_STN = 2'h1;
   localparam logic [1:0] PANEL_TFT       = 2'h2;
   localparam logic [1:0] ORDER_LE     = 2'h0;
   localparam logic [1:0] ORDER_BE     = 2'h1;
   localparam logic [1:0] ORDER_PACKED = 2'h2;
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
endpackage

// File: rtl/lcd_fifo.sv
/*
 * Display data buffer in flip-flops, width and depth as parameters.
 * Assumes a single clock; flush empties it in one cycle.
 */
`timescale 1ns/1ps
module lcd_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic             doPush;
   logic             doPop;

   assign inReady  = count != (AW+1)'(DEPTH);
   assign outValid = count != '0;
   assign outData  = mem[rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outReady && outValid;

   always_ff @(posedge mclk)
   begin
      if (doPush)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst || flush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         if (doPush)
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         if (doPop)
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
   end
endmodule

// File: rtl/lcd_palette.sv
/*
 * Colour lookup table: 32-bit words holding two 16-bit entries each,
 * even entry in the low half. One word write port, two entry read ports.
 * Assumes reads are combinational and sampled by the caller.
 */
`timescale 1ns/1ps
module lcd_palette
   import lcd_pkg::*;
(
   input  wire logic                           mclk,
   input  wire logic                           palWrEn,
   input  wire logic [$clog2(lcd_pkg::PAL_WORDS)-1:0] palWrAddr,
   input  wire logic [31:0]                    palWrData,
   input  wire logic [lcd_pkg::PAL_IDX_W-1:0]  rdIdxA,
   input  wire logic [lcd_pkg::PAL_IDX_W-1:0]  rdIdxB,
   output logic      [15:0]                    rdEntryA,
   output logic      [15:0]                    rdEntryB
);
   logic [31:0] mem [PAL_WORDS];
   logic [31:0] wordA;
   logic [31:0] wordB;

   always_ff @(posedge mclk)
   begin
      if (palWrEn)
         mem[palWrAddr] <= palWrData;
   end

   assign wordA    = mem[rdIdxA[PAL_IDX_W-1:1]];
   assign wordB    = mem[rdIdxB[PAL_IDX_W-1:1]];
   assign rdEntryA = rdIdxA[0] ? wordA[31:16] : wordA[15:0];
   assign rdEntryB = rdIdxB[0] ? wordB[31:16] : wordB[15:0];
endmodule

// File: sim/frame_memory_model.sv
/* Frame memory answering single-beat bus reads, promptly, slowly or never.
   Assumes the controller's master port and one clock. */
`timescale 1ns/1ps
module frame_memory_model
   import lcd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        starve,
   input  wire logic        slow,
   input  wire logic [31:0] hAddr,
   input  wire logic [1:0]  hTrans,
   output logic             hReady,
   output logic [31:0]      hRData
);
   logic [31:0] addrQ;
   logic        dataPhase;
   // Idle bus shows inverted data so stale words never look valid
   assign hRData = dataPhase ? (addrQ ^ 32'hA5A5_0000) : ~addrQ;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         hReady <= 1'b1;
         dataPhase <= 1'b0;
         addrQ <= 32'h0000_0000;
      end
      else
      begin
         hReady <= !starve && (!slow || !hReady);
         if (hReady && hTrans == HTRANS_NONSEQ)
         begin
            addrQ <= hAddr;
            dataPhase <= 1'b1;
         end
         else if (hReady)
            dataPhase <= 1'b0;
      end
   end
endmodule

// File: sim/lcd_panel_controller_chk.sv
/* Port assertions of the panel controller.
   Assumes it is bound to every controller instance. */
`timescale 1ns/1ps
module lcd_panel_controller_chk
   import lcd_pkg::*;
(
   input wire logic                      mclk,
   input wire logic                      rst,
   input wire logic                      enable,
   input wire logic [1:0]                panelType,
   input wire logic                      useExtClk,
   input wire logic [lcd_pkg::DIV_W-1:0] pixDiv,
   input wire logic                      underflowIrqEn,
   input wire logic                      underflowClr,
   input wire logic [31:0]               hAddr,
   input wire logic [1:0]                hTrans,
   input wire logic [2:0]                hSize,
   input wire logic                      hWrite,
   input wire logic                      hReady,
   input wire logic                      lcdPixClk,
   input wire logic                      lcdLineSync,
   input wire logic                      lcdFrameSync,
   input wire logic                      lcdAcBias,
   input wire logic                      lcdUnderflow,
   input wire logic                      lcdIrq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_read_only: assert property (hWrite == 1'b0 && hSize == HSIZE_WORD)
      else $error("master port left word reads");
   a_addr_hold: assert property (hTrans == HTRANS_NONSEQ && !hReady |=>
      hTrans == HTRANS_NONSEQ && $stable(hAddr)) else $error("request dropped in wait");
   a_idle_between: assert property (hTrans == HTRANS_NONSEQ && hReady |=>
      hTrans == HTRANS_IDLE) else $error("no idle after beat");
   a_off_quiet: assert property (!enable [*2] |=>
      !lcdLineSync && !lcdFrameSync && !lcdAcBias) else $error("panel active while off");
   a_de_sync: assert property (panelType == PANEL_TFT && lcdLineSync |-> !lcdAcBias)
      else $error("data enable during sync");
   a_div_high: assert property (enable && !useExtClk && pixDiv == 8'h01 &&
      $rose(lcdPixClk) |=> lcdPixClk ##1 !lcdPixClk) else $error("pixel clock width");
   a_flag_sticky: assert property (lcdUnderflow && !underflowClr |=> lcdUnderflow)
      else $error("underflow flag lost");
   a_irq_mask: assert property (!$past(underflowIrqEn) |-> !lcdIrq)
      else $error("masked interrupt raised");
   a_irq_flag: assert property (lcdIrq |-> lcdUnderflow)
      else $error("interrupt without flag");
endmodule
bind lcd_panel_controller lcd_panel_controller_chk chk (.mclk, .rst, .enable, .panelType,
   .useExtClk, .pixDiv, .underflowIrqEn, .underflowClr, .hAddr, .hTrans, .hSize, .hWrite,
   .hReady, .lcdPixClk, .lcdLineSync, .lcdFrameSync, .lcdAcBias, .lcdUnderflow, .lcdIrq);

// File: sim/tb_lcd_panel_controller.sv
/* Self-checking bench of the panel controller with a frame memory model.
   Assumes 15-pixel lines of 4 clocks and 8-line frames. */
`timescale 1ns/1ps
module tb_lcd_panel_controller;
   import lcd_pkg::*;
   logic mclk = 0, rst = 1, enable = 0, dualPanel = 0, mono8Bit = 0, useExtClk = 0;
   logic pixClkIn = 0, palWrEn = 1, cursorEn = 1, underflowIrqEn = 0, underflowClr = 0;
   logic starve = 0, slow = 1, extRun = 0, hWrite, hReady;
   logic lcdPixClk, lcdLineSync, lcdFrameSync, lcdAcBias, lcdUnderflow, lcdIrq;
   logic [1:0] panelType = PANEL_TFT, pixOrder = ORDER_LE, hTrans;
   logic [2:0] bppSel = BPP_16, hSize;
   logic [DIV_W-1:0] pixDiv = 8'h01;
   logic [POS_W-1:0] hActive = 12'h008, vActive = 12'h004, cursorX = 0, cursorY = 0;
   logic [PORCH_W-1:0] hFront = 8'h02, hSyncW = 8'h03, hBack = 8'h02;
   logic [PORCH_W-1:0] vFront = 8'h01, vSyncW = 8'h02, vBack = 8'h01;
   logic [31:0] upperBase = 32'h0000_1000, lowerBase = 32'h0000_2000, hAddr, hRData;
   logic [31:0] palWrData = 32'h7FFF_001F;
   logic [WORDS_W-1:0] panelWords = 20'h0_0010;
   logic [6:0] palWrAddr = 7'h00;
   logic [DATA_W-1:0] cursorColor = 24'hFF_0000, lcdData;
   int errors = 0, checked = 0, cycles = 0, pinRises = 0;
   lcd_panel_controller uut (.mclk, .rst, .enable, .panelType, .dualPanel, .mono8Bit,
      .bppSel, .pixOrder, .useExtClk, .pixClkIn, .pixDiv, .hActive, .hFront, .hSyncW, .hBack,
      .vActive, .vFront, .vSyncW, .vBack, .upperBase, .lowerBase, .panelWords, .palWrEn,
      .palWrAddr, .palWrData, .cursorEn, .cursorX, .cursorY, .cursorColor, .underflowIrqEn,
      .underflowClr, .hAddr, .hTrans, .hSize, .hWrite, .hReady, .hRData, .lcdPixClk,
      .lcdLineSync, .lcdFrameSync, .lcdAcBias, .lcdData, .lcdUnderflow, .lcdIrq);
   frame_memory_model mem (.mclk, .rst, .starve, .slow, .hAddr, .hTrans, .hReady, .hRData);
   always #2 mclk = ~mclk;
   // Pin period unrelated to the system clock
   always #9.3 if (extRun) pixClkIn = ~pixClkIn;
   always @(posedge pixClkIn) pinRises++;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_for(input int sel);
      for (int n = 0; n < 3000; n++)
      begin
         if ((sel == 0 && hTrans === HTRANS_NONSEQ) || (sel == 1 && hTrans === HTRANS_NONSEQ
            && hReady === 1'b1) || (sel == 2 && lcdUnderflow === 1'b1)
            || (sel == 3 && lcdAcBias === 1'b1) || (sel == 4 && lcdFrameSync === 1'b1))
            return;
         @(negedge mclk);
      end
      errors++;
      $display("wait %0d timed out at %0t", sel, $time);
   endtask
   function automatic logic pick(input int sel);
      return sel ? lcdFrameSync : lcdLineSync;
   endfunction
   task automatic measure(input int sel, output int hi, output int per);
      while (pick(sel) !== 1'b0) @(negedge mclk);
      while (pick(sel) !== 1'b1 && per < 3000) begin per++; @(negedge mclk); end
      hi = 0;
      per = 0;
      while (pick(sel) === 1'b1 && per < 3000) begin hi++; per++; @(negedge mclk); end
      while (pick(sel) !== 1'b1 && per < 3000) begin per++; @(negedge mclk); end
   endtask
   task automatic t_fetch;
      enable = 1;
      wait_for(0);
      check(hAddr, upperBase);
      wait_for(1);
      @(negedge mclk);
      wait_for(0);
      check(hAddr, upperBase + 32'h0000_0004);
      $display("fetch test done");
   endtask
   task automatic t_timing;
      int hi, per;
      slow = 0;
      per = 0;
      measure(0, hi, per);
      check(hi, 32'(hSyncW) * 4);
      check(per, 60);
      measure(1, hi, per);
      check(hi, 32'(vSyncW) * 60);
      check(per, 480);
      wait_for(3);
      check(lcdData, cursorColor);
      cursorEn = 0;
      wait_for(4);
      wait_for(3);
      check(lcdData, 24'h10_0000);
      $display("timing test done");
   endtask
   task automatic t_underflow;
      // Start-up frame underflows by design, so clear before starving
      underflowClr = 1;
      @(negedge mclk);
      underflowClr = 0;
      check(lcdUnderflow, 0);
      starve = 1;
      wait_for(2);
      repeat (2) @(negedge mclk);
      check(lcdUnderflow, 1);
      check(lcdIrq, 0);
      underflowIrqEn = 1;
      repeat (3) @(negedge mclk);
      check(lcdIrq, 1);
      starve = 0;
      repeat (4) @(negedge mclk);
      enable = 0;
      underflowClr = 1;
      repeat (3) @(negedge mclk);
      underflowClr = 0;
      repeat (2) @(negedge mclk);
      check({lcdUnderflow, lcdIrq, lcdData}, 0);
      $display("underflow test done");
   endtask
   task automatic t_ext_clock;
      int rises;
      logic prev;
      useExtClk = 1;
      extRun = 1;
      enable = 1;
      repeat (20) @(negedge mclk);
      rises = 0;
      pinRises = 0;
      prev = lcdPixClk;
      repeat (400)
      begin
         @(negedge mclk);
         if (lcdPixClk && !prev)
            rises++;
         prev = lcdPixClk;
      end
      check(32'((pinRises - rises) <= 2 && (rises - pinRises) <= 2), 1);
      $display("external clock test done");
   endtask
   initial
   begin
      repeat (4) @(negedge mclk);
      rst = 0;
      palWrEn = 0;
      check({hSize, hTrans, lcdData, lcdUnderflow}, {HSIZE_WORD, 27'h000_0000});
      t_fetch();
      t_timing();
      t_underflow();
      t_ext_clock();
      stop_test();
   end
endmodule
